// [bench/sp_asserts.sv]
// Purpose: port checks of the serial port control block
// Assumes: bench leaves one idle cycle after each register access
// Notes:   bound to sp_uart
`timescale 1ns/1ns
`include "sp_consts.svh"
module sp_asserts (
  // clock and reset
  input wire logic            mclk,
  input wire logic            rst_n,
  // register port
  input wire sp_pkg::sp_req_t req,
  input wire logic [7:0]      rd_data,
  // rate source and pins
  input wire logic            t1_ovf,
  input wire logic            rxd_in,
  input wire logic            rxd_out,
  input wire logic            rxd_oe,
  input wire logic            txd
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // address outside the map
  wire logic unmapped = req.addr != `SP_A_SERIAL_CONTROL_REG && req.addr != `SP_A_SERIAL_BUFFER_REG && req.addr != `SP_A_POWER_CONTROL_REG;
  // read data only in the slot after a read
  a_rd_idle_zero:
    assert property (!req.rd |=> rd_data == 8'h00) else $error("read data outside read slot");
  a_unmapped_rd:
    assert property (req.rd && unmapped |=> rd_data == 8'h00) else $error("unmapped read not zero");
  // software fields read back as written, data pin high while released
  a_ctl_keep:
    assert property (req.wr && req.addr == `SP_A_SERIAL_CONTROL_REG ##2 req.rd && req.addr == `SP_A_SERIAL_CONTROL_REG
      |=> rd_data[6:3] == $past(req.wdata[6:3], 3)) else $error("control field lost");
  a_unmapped_wr:
    assert property (req.wr && req.addr == `SP_A_SERIAL_CONTROL_REG ##2 req.wr && unmapped ##2 req.rd && req.addr == `SP_A_SERIAL_CONTROL_REG
      |=> rd_data[6:3] == $past(req.wdata[6:3], 5)) else $error("unmapped write changed control");
  a_pwr_back:
    assert property (req.wr && req.addr == `SP_A_POWER_CONTROL_REG ##2 req.rd && req.addr == `SP_A_POWER_CONTROL_REG
      |=> rd_data == {$past(req.wdata[7:6], 3), 6'h00}) else $error("power control readback wrong");
  a_out_idle:
    assert property (!rxd_oe |-> rxd_out) else $error("data pin driven low while released");
  // shift clock three low, three high, data steady while high
  a_shift_low:
    assert property (rxd_oe && $fell(txd) |-> (!txd)[*3] ##1 txd) else $error("shift clock low phase wrong");
  a_shift_high:
    assert property (rxd_oe && $rose(txd) |-> (txd && $stable(rxd_out))[*3]) else $error("shift high phase wrong");
  // main scenarios
  c_shift_tx: cover property (rxd_oe);
  c_buf_wr: cover property (req.wr && req.addr == `SP_A_SERIAL_BUFFER_REG);
  c_async_tx: cover property ($fell(txd) && !rxd_oe);
  c_shift_rx: cover property (!txd && !rxd_oe);
endmodule : sp_asserts
bind sp_uart sp_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .t1_ovf(t1_ovf),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));

// [bench/sp_peer.sv]
// Purpose: remote asynchronous peer on the serial pins
// Assumes: bit period given in clocks
// Notes:   line idles high between frames
`timescale 1ns/1ns
module sp_peer (
  // clock
  input  wire logic mclk,
  // serial pins
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  // start bit, n bits lsb first, then idle high
  task automatic send(input logic [9:0] bits, input int n, input int per);
    rxd <= 1'b0;
    repeat (per) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (per) @(posedge mclk);
    end
    rxd <= 1'b1;
    repeat (per) @(posedge mclk);
  endtask : send
  // wait for start, sample each bit at its middle
  task automatic recv(input int n, input int per, output logic [9:0] bits);
    bits = 10'h000;
    wait (txd === 1'b0);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      repeat (per) @(posedge mclk);
      bits[i] = txd;
    end
  endtask : recv
endmodule : sp_peer

// [bench/tb_top.sv]
// Purpose: register level tests of the serial port
// Assumes: peer model on the pins
// Notes:   frames at 16 or 32 clocks per bit
`timescale 1ns/1ns
`include "sp_consts.svh"
module tb_top;
  logic            mclk, rst_n, t1_ovf, ovf_on, rxd_out, rxd_oe, txd, peer_rxd;
  sp_pkg::sp_req_t req;
  logic [7:0]      rd_data, b;
  logic [9:0]      f;
  int              mismatches, total_checks;
  // data pin level from both drivers
  wire logic rxd_line = rxd_oe ? rxd_out : peer_rxd;
  sp_uart dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .t1_ovf(t1_ovf),
    .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  sp_peer peer (.mclk(mclk), .txd(txd), .rxd(peer_rxd));
  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // overflow pulse every second clock
  always @(posedge mclk) t1_ovf <= ovf_on & ~t1_ovf;
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk("register", {2'b00, rd_data & m}, {2'b00, e});
    @(posedge mclk);
  endtask : rc
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    ovf_on = 1'b0;
    t1_ovf = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rc(`SP_A_SERIAL_CONTROL_REG, 8'hff, `SP_SERIAL_CONTROL_REG_RST);
    rc(`SP_A_POWER_CONTROL_REG, 8'hff, 8'h00);
    rc(8'h55, 8'hff, 8'h00);
    wr(`SP_A_SERIAL_CONTROL_REG, 8'hc8);
    wr(8'h55, 8'h00);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'hff, 8'hc8);
    wr(`SP_A_POWER_CONTROL_REG, 8'hc0);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'hff, 8'h48);
    rc(`SP_A_POWER_CONTROL_REG, 8'hff, 8'hc0);
    // mode 2 doubled: 16 clocks a bit
    wr(`SP_A_POWER_CONTROL_REG, 8'h80);
    wr(`SP_A_SERIAL_CONTROL_REG, 8'h98);
    wr(`SP_A_SERIAL_BUFFER_REG, 8'ha5);
    peer.recv(10, 16, f);
    chk("frame", f, 10'h3a5);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h02, 8'h02);
    peer.send(10'h23c, 10, 16);
    rc(`SP_A_SERIAL_BUFFER_REG, 8'hff, 8'h3c);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h05, 8'h01);
    // multiprocessor filter on the ninth bit
    wr(`SP_A_SERIAL_CONTROL_REG, 8'hb8);
    peer.send(10'h2c3, 10, 16);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h01, 8'h00);
    peer.send(10'h3c3, 10, 16);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h05, 8'h05);
    rc(`SP_A_SERIAL_BUFFER_REG, 8'hff, 8'hc3);
    // reception off
    wr(`SP_A_SERIAL_CONTROL_REG, 8'ha8);
    peer.send(10'h3aa, 10, 16);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h01, 8'h00);
    rc(`SP_A_SERIAL_BUFFER_REG, 8'hff, 8'hc3);
    // mode 1 from overflows, doubled: 32 clocks a bit
    ovf_on <= 1'b1;
    wr(`SP_A_SERIAL_CONTROL_REG, 8'h70);
    peer.send(10'h081, 9, 32);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h01, 8'h00);
    wr(`SP_A_POWER_CONTROL_REG, 8'hc0);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h80, 8'h80);
    peer.send(10'h142, 9, 32);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h81, 8'h81);
    rc(`SP_A_SERIAL_BUFFER_REG, 8'hff, 8'h42);
    // shift mode transmit
    wr(`SP_A_POWER_CONTROL_REG, 8'h00);
    wr(`SP_A_SERIAL_CONTROL_REG, 8'h00);
    wr(`SP_A_SERIAL_BUFFER_REG, 8'h5a);
    repeat (8) begin
      @(posedge txd);
      @(negedge mclk);
      b = {rxd_out, b[7:1]};
    end
    chk("shift byte", {2'b00, b}, 10'h05a);
    repeat (12) @(posedge mclk);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h02, 8'h02);
    // shift mode receive of an idle-high line
    wr(`SP_A_SERIAL_CONTROL_REG, 8'h10);
    repeat (60) @(posedge mclk);
    rc(`SP_A_SERIAL_CONTROL_REG, 8'h01, 8'h01);
    rc(`SP_A_SERIAL_BUFFER_REG, 8'hff, 8'hff);
    stop_test();
  end
endmodule : tb_top

// [hw/sp_consts.svh]
// Purpose: address map, reset values and counts of the serial port
// Assumes: 8-bit register port, one clock
// Notes:   definitions only
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH
`define SP_A_SERIAL_CONTROL_REG   8'h98
`define SP_A_SERIAL_BUFFER_REG   8'h99
`define SP_A_POWER_CONTROL_REG   8'h87
`define SP_SERIAL_CONTROL_REG_RST 8'h00
// power control bit positions
`define SP_P_DBL    7
`define SP_P_EVS    6
// mode field codes
`define SP_MD_SHIFT 2'h0
`define SP_MD_8VAR  2'h1
`define SP_MD_9FIX  2'h2
// shift mode: six clocks per bit, clock rises at phase 3
`define SP_M0_LAST  3'h5
`define SP_M0_RISE  3'h3
// async: sixteen ticks per bit, majority at 7,8,9
`define SP_OS_LAST  4'hf
`define SP_OS_S1    4'h7
`define SP_OS_S2    4'h8
`define SP_OS_S3    4'h9
// last bit index of a frame, then index of the eighth data bit
`define SP_LST_M0   4'h7
`define SP_LST_8    4'h9
`define SP_LST_9    4'ha
`define SP_IDX_D8   4'h8
`endif

// [hw/sp_pkg.sv]
// Purpose: types of the serial port
// Assumes: nothing
// Notes:   one-hot states, one state record
package sp_pkg;
  typedef enum logic [2:0] {SP_TX_IDLE = 3'h1, SP_TX_WAIT = 3'h2, SP_TX_RUN = 3'h4} sp_tx_t;
  typedef enum logic [2:0] {SP_RX_IDLE = 3'h1, SP_RX_RUN = 3'h2, SP_RX_SH = 3'h4} sp_rx_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sp_req_t;
  typedef struct packed {
    logic        sm0, sm1, mpe, ren, tb8, rb8, ti, ri, fe, dbl, evs;
    logic [7:0]  rx_buf;
    logic [7:0]  rd_data;
    logic        txd, rxo, rxoe;
    logic        rx_s1, rx_s2, rx_prev;
    logic        half;
    logic [2:0]  p6;
    logic [3:0]  tdiv;
    sp_tx_t      tst;
    logic [10:0] tfr;
    logic [3:0]  tidx;
    sp_rx_t      rst;
    logic [3:0]  rdiv;
    logic [3:0]  ridx;
    logic [7:0]  rsh;
    logic        r9, sa, sb;
  } sp_state_t;
endpackage : sp_pkg

// [hw/sp_uart.sv]
// Purpose: serial port mode, flag and bit rate control with shift engines
// Assumes: timer1 overflow pulse comes from logic on mclk
// Notes:   all state in one record, registered once per edge
//
// Functional notes
// RULE_01: stop bit received as zero sets sticky framing error until software clears.
// RULE_02: control bit 7 reads framing error if view select set, else mode high.
// RULE_03: mode field picks shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// RULE_04: 9-bit modes with multiproc enable drop frames whose ninth bit is zero.
// RULE_05: 8-bit mode with multiproc enable drops frames lacking a valid stop.
// RULE_06: software keeps multiproc enable zero in shift mode.
// RULE_07: receive enable gates reception; clearing it stops reception.
// RULE_08: 9-bit modes transmit the written tx ninth bit.
// RULE_09: rx ninth bit holds ninth bit, or stop bit in 8-bit mode.
// RULE_10: tx done sets after 8th bit in shift mode, else at stop start.
// RULE_11: rx done sets after 8th bit in shift mode, else mid stop.
// RULE_12: shift mode bit rate is clock over six.
// RULE_13: fixed 9-bit mode rate is clock over 32, or 16 doubled.
// RULE_14: variable modes time bits from timer1 overflows, halved unless doubled.
// RULE_15: software keeps the timer1 interrupt disabled when it times bits.
// RULE_16: any timer1 overflow pulse is accepted as the rate source.
// RULE_17: control register resets to zero.
// RULE_18: any buffer write starts a transmission in every mode.
// RULE_19: shift mode receives when rx done clear and enabled; else on start. Shift mode here also waits for the transmitter to be idle.
// RULE_20: tick source is chosen from the mode field every cycle.
`timescale 1ns/1ns
`include "sp_consts.svh"
module sp_uart (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // register port
  input  wire sp_pkg::sp_req_t req,
  output logic [7:0]           rd_data,
  // rate source
  input  wire logic            t1_ovf,
  // serial pins
  input  wire logic            rxd_in,
  output logic                 rxd_out,
  output logic                 rxd_oe,
  output logic                 txd
);
  sp_pkg::sp_state_t s_ff;
  sp_pkg::sp_state_t nxt_s;
  logic [1:0] mode;
  logic       wsc;
  logic       wsb;
  logic       tk;
  logic       bnd;
  logic       maj;
  logic       ok;
  logic       tx_set;
  logic       rx_set;
  logic       fe_set;
  logic [3:0] lst;

  // next state of the whole port
  always_comb begin
    nxt_s  = s_ff;
    mode   = {s_ff.sm0, s_ff.sm1}; // RULE_03
    wsc    = req.wr && (req.addr == `SP_A_SERIAL_CONTROL_REG);
    wsb    = req.wr && (req.addr == `SP_A_SERIAL_BUFFER_REG);
    tx_set = 1'b0;
    rx_set = 1'b0;
    fe_set = 1'b0;
    maj    = 1'b0;
    ok     = 1'b0;
    // pin synchroniser
    nxt_s.rx_s1   = rxd_in;
    nxt_s.rx_s2   = s_ff.rx_s1;
    nxt_s.rx_prev = s_ff.rx_s2;
    // tick source per mode
    case (mode) // RULE_20
      `SP_MD_SHIFT: tk = 1'b0;
      `SP_MD_9FIX:  tk = s_ff.dbl | s_ff.half; // RULE_13
      default:      tk = t1_ovf & (s_ff.dbl | s_ff.half); // RULE_14 RULE_16
    endcase
    nxt_s.half = s_ff.half ^ ((mode == `SP_MD_9FIX) | t1_ovf);
    nxt_s.p6   = (s_ff.p6 == `SP_M0_LAST) ? 3'h0 : s_ff.p6 + 3'h1; // RULE_12
    nxt_s.tdiv = s_ff.tdiv + {3'h0, tk};
    bnd = (mode == `SP_MD_SHIFT) ? (s_ff.p6 == `SP_M0_LAST) : (tk && s_ff.tdiv == `SP_OS_LAST);
    case (mode)
      `SP_MD_SHIFT: lst = `SP_LST_M0;
      `SP_MD_8VAR:  lst = `SP_LST_8;
      default:      lst = `SP_LST_9;
    endcase
    // transmitter
    if (wsb) begin // RULE_18
      nxt_s.tfr  = {1'b1, (mode[1] ? s_ff.tb8 : 1'b1), req.wdata, 1'b0}; // RULE_08
      if (mode == `SP_MD_SHIFT) begin
        nxt_s.tfr = {3'h7, req.wdata};
      end
      nxt_s.tst  = sp_pkg::SP_TX_WAIT;
      nxt_s.tidx = 4'h0;
    end else begin
      case (s_ff.tst)
        sp_pkg::SP_TX_IDLE: nxt_s.tst = sp_pkg::SP_TX_IDLE;
        sp_pkg::SP_TX_WAIT: if (bnd) begin
          nxt_s.tst = sp_pkg::SP_TX_RUN;
        end
        sp_pkg::SP_TX_RUN: if (bnd) begin
          if (s_ff.tidx >= lst) begin
            tx_set    = (mode == `SP_MD_SHIFT); // RULE_10
            nxt_s.tst = sp_pkg::SP_TX_IDLE;
          end else begin
            nxt_s.tfr  = {1'b1, s_ff.tfr[10:1]};
            nxt_s.tidx = s_ff.tidx + 4'h1;
            tx_set     = (mode != `SP_MD_SHIFT) && (s_ff.tidx + 4'h1 == lst); // RULE_10
          end
        end
        default: nxt_s.tst = sp_pkg::SP_TX_IDLE;
      endcase
    end
    // receiver
    case (s_ff.rst)
      sp_pkg::SP_RX_IDLE: begin
        if (mode == `SP_MD_SHIFT) begin
          if (s_ff.ren && !s_ff.ri && s_ff.tst == sp_pkg::SP_TX_IDLE && bnd) begin // RULE_19
            nxt_s.rst  = sp_pkg::SP_RX_SH;
            nxt_s.ridx = 4'h0;
          end
        end else if (s_ff.ren && s_ff.rx_prev && !s_ff.rx_s2) begin // RULE_19
          nxt_s.rst  = sp_pkg::SP_RX_RUN;
          nxt_s.rdiv = 4'h0;
          nxt_s.ridx = 4'h0;
        end
      end
      sp_pkg::SP_RX_RUN: if (tk) begin
        nxt_s.rdiv = s_ff.rdiv + 4'h1;
        if (s_ff.rdiv == `SP_OS_S1) begin
          nxt_s.sa = s_ff.rx_s2;
        end
        if (s_ff.rdiv == `SP_OS_S2) begin
          nxt_s.sb = s_ff.rx_s2;
        end
        if (s_ff.rdiv == `SP_OS_LAST) begin
          nxt_s.ridx = s_ff.ridx + 4'h1;
        end
        if (s_ff.rdiv == `SP_OS_S3) begin
          maj = (s_ff.sa & s_ff.sb) | (s_ff.sa & s_ff.rx_s2) | (s_ff.sb & s_ff.rx_s2);
          if (s_ff.ridx == 4'h0) begin
            if (maj) begin
              nxt_s.rst = sp_pkg::SP_RX_IDLE; // false start
            end
          end else if (s_ff.ridx == lst) begin
            fe_set = !maj; // RULE_01
            // RULE_04 RULE_05
            ok = !s_ff.ri && (!s_ff.mpe || ((mode == `SP_MD_8VAR) ? maj : s_ff.r9));
            if (ok) begin
              nxt_s.rx_buf = s_ff.rsh;
              nxt_s.rb8    = (mode == `SP_MD_8VAR) ? maj : s_ff.r9; // RULE_09
              rx_set       = 1'b1; // RULE_11
            end
            nxt_s.rst = sp_pkg::SP_RX_IDLE;
          end else if (s_ff.ridx <= `SP_IDX_D8) begin
            nxt_s.rsh = {maj, s_ff.rsh[7:1]};
          end else begin
            nxt_s.r9 = maj;
          end
        end
      end
      sp_pkg::SP_RX_SH: begin
        if (s_ff.p6 == `SP_M0_RISE) begin
          nxt_s.rsh = {s_ff.rx_s2, s_ff.rsh[7:1]};
        end
        if (bnd) begin
          if (s_ff.ridx == `SP_LST_M0) begin
            nxt_s.rx_buf = s_ff.rsh;
            rx_set       = 1'b1; // RULE_11
            nxt_s.rst    = sp_pkg::SP_RX_IDLE;
          end else begin
            nxt_s.ridx = s_ff.ridx + 4'h1;
          end
        end
      end
      default: nxt_s.rst = sp_pkg::SP_RX_IDLE;
    endcase
    if (!s_ff.ren) begin
      nxt_s.rst = sp_pkg::SP_RX_IDLE; // RULE_07
    end
    // control register writes; hardware sets of fe, ti and ri win over clears
    if (wsc) begin
      if (s_ff.evs) begin
        nxt_s.fe = req.wdata[7]; // RULE_02
      end else begin
        nxt_s.sm0 = req.wdata[7];
      end
      nxt_s.sm1 = req.wdata[6];
      nxt_s.mpe = req.wdata[5];
      nxt_s.ren = req.wdata[4];
      nxt_s.tb8 = req.wdata[3];
      nxt_s.rb8 = req.wdata[2];
      nxt_s.ti  = req.wdata[1];
      nxt_s.ri  = req.wdata[0];
    end
    nxt_s.fe = nxt_s.fe | fe_set; // RULE_01
    nxt_s.ti = nxt_s.ti | tx_set; // RULE_10
    nxt_s.ri = nxt_s.ri | rx_set; // RULE_11
    if (req.wr && req.addr == `SP_A_POWER_CONTROL_REG) begin
      nxt_s.dbl = req.wdata[`SP_P_DBL];
      nxt_s.evs = req.wdata[`SP_P_EVS];
    end
    // read data, valid the cycle after the strobe
    nxt_s.rd_data = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `SP_A_SERIAL_CONTROL_REG: nxt_s.rd_data = {(s_ff.evs ? s_ff.fe : s_ff.sm0), s_ff.sm1, s_ff.mpe, // RULE_02
                                     s_ff.ren, s_ff.tb8, s_ff.rb8, s_ff.ti, s_ff.ri};
        `SP_A_SERIAL_BUFFER_REG: nxt_s.rd_data = s_ff.rx_buf;
        `SP_A_POWER_CONTROL_REG: nxt_s.rd_data = {s_ff.dbl, s_ff.evs, 6'h00};
        default:    nxt_s.rd_data = 8'h00;
      endcase
    end
    // pin drive: shift mode uses rxd both ways and txd as shift clock
    if (mode == `SP_MD_SHIFT) begin
      nxt_s.rxoe = (nxt_s.tst == sp_pkg::SP_TX_RUN);
      // the data pin is released high unless a shift-mode transmit is running
      nxt_s.rxo  = (nxt_s.tst == sp_pkg::SP_TX_RUN) ? nxt_s.tfr[0] : 1'b1;
      nxt_s.txd  = !((nxt_s.tst == sp_pkg::SP_TX_RUN || nxt_s.rst == sp_pkg::SP_RX_SH)
                     && nxt_s.p6 < `SP_M0_RISE);
    end else begin
      nxt_s.rxoe = 1'b0;
      nxt_s.rxo  = 1'b1;
      nxt_s.txd  = (nxt_s.tst == sp_pkg::SP_TX_RUN) ? nxt_s.tfr[0] : 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff         <= '0;
      {s_ff.sm0, s_ff.sm1, s_ff.mpe, s_ff.ren, s_ff.tb8, s_ff.rb8, s_ff.ti, s_ff.ri} <= `SP_SERIAL_CONTROL_REG_RST; // RULE_17
      s_ff.txd     <= 1'b1;
      s_ff.rxo     <= 1'b1;
      s_ff.rx_s1   <= 1'b1;
      s_ff.rx_s2   <= 1'b1;
      s_ff.rx_prev <= 1'b1;
      s_ff.tst     <= sp_pkg::SP_TX_IDLE;
      s_ff.rst     <= sp_pkg::SP_RX_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_data = s_ff.rd_data;
  assign txd     = s_ff.txd;
  assign rxd_out = s_ff.rxo;
  assign rxd_oe  = s_ff.rxoe;
endmodule : sp_uart
